// ### rtl/rssi_ed_defs.svh
// Constants for the received-strength and energy-detection status block.
`ifndef RSSI_ED_DEFS_SVH
`define RSSI_ED_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_TRX_CTRL_ONE      6'h04
`define OFS_QUALITY_STATUS    6'h06
`define OFS_ENERGY_LEVEL      6'h07

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_AUTO_CRC_BIT     5
`define STAT_CRC_BIT          7
`define STAT_STRENGTH_MSB     4
`define STAT_STRENGTH_LSB     0
`define AUTO_CRC_RESET        1'b1
`define ENERGY_RESET          8'hff
`define STRENGTH_RESET        5'h00
`define STRENGTH_MAX          5'h1c
`define STRENGTH_STEP_DB      10'h003
`define ENERGY_MAX            8'h54
`define ED_LAST_SAMPLE        3'h7
`define ED_AVG_SHIFT          3

// ****************************************************************
// Timing, in nanoseconds
// ****************************************************************
`define CLK_PERIOD_NS         10
`define STRENGTH_TIME_NS      2000
`define ED_MEAS_TIME_NS       128000
`define ED_SHORT_TIME_NS      32000
`define ED_TOTAL_TIME_NS      140000

`endif

// ### rtl/rssi_ed_pkg.sv
// Types shared by the received-strength and energy-detection status block.
package rssi_ed_pkg;

   // Register access request from the serial port front end.
   typedef struct packed {
      logic       we;
      logic       re;
      logic [5:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Receiver indications from the transceiver core, same clock.
   typedef struct packed {
      logic       listen;
      logic       busy;
      logic       high_rate;
      logic       shr_detect;
      logic       frame_end;
      logic       crc_ok;
      logic [4:0] raw_strength;
   } rx_ind_t;

   // Phases of an energy measurement.
   typedef enum logic [1:0] {
      ED_IDLE,
      ED_MEAS,
      ED_PROC
   } ed_phase_t;

   // Complete state of the block.
   typedef struct packed {
      ed_phase_t  phase;
      logic [15:0] sub_cnt;
      logic [2:0] samp_cnt;
      logic [9:0] acc;
      logic       manual;
      logic       short_win;
      logic [7:0] tick_cnt;
      logic [4:0] strength;
      logic       crc_valid;
      logic       auto_crc;
      logic [7:0] energy;
      logic       done;
      logic [7:0] rdata;
   } block_state_t;

endpackage

// ### rtl/rssi_energy_detect_status.sv
// Received-strength, energy-detection and checksum status logic of the receiver.
//
// What this block does
// - Auto-checksum control bit enables or disables transmit checksum generation.
// - Checksum-valid bit reads 1 for a good last frame, 0 otherwise.
// - Checksum-valid bit changes only at frame end and holds until the next.
// - Strength field is bits 4..0, range 0 to 28, 3 dB steps.
// - In receive states strength is refreshed every 2 us.
// - Strength 0 is below -91 dBm; codes 1..28 rise linearly by 3 dB.
// - A write to the energy register in listen or busy state starts a manual measurement.
// - Preamble detection starts an automatic measurement, with no done event unless it preempts a manual run.
// - Manual measurement needs listen or busy state; done event at finish.
// - Manual request outside receive gives done event but no measurement.
// - Eight-symbol average stored 140 us after start, 128 us measuring.
// - High-rate automatic measurement takes 32 us; manual in listen 128 us.
// - Energy value stays valid until a newer measurement replaces it.
// - Energy register is 8 bits, resets to ff, results 00 to 54.
// - Energy code 0 is at most -91 dBm; each code adds 1 dB.
`timescale 1ns/1ps
`include "rssi_ed_defs.svh"

module rssi_energy_detect_status #(
   parameter int MEAS_CYC  = `ED_MEAS_TIME_NS / `CLK_PERIOD_NS,
   parameter int SHORT_CYC = `ED_SHORT_TIME_NS / `CLK_PERIOD_NS
) (
   // Clock and reset.
   input  wire logic                  clock,
   input  wire logic                  rst_b,
   // Register port from the serial front end.
   input  wire rssi_ed_pkg::reg_req_t req,
   output logic [7:0]                 rdata,
   // Receiver indications.
   input  wire rssi_ed_pkg::rx_ind_t  rx,
   // Status towards the rest of the transceiver.
   output logic [4:0]                 strength,
   output logic [7:0]                 energy_value,
   output logic                       crc_valid,
   output logic                       tx_auto_crc_en,
   output logic                       measurement_done_event
);
   import rssi_ed_pkg::*;

   // ****************************************************************
   // Derived cycle counts
   // ****************************************************************
   localparam logic [15:0] LONG_IV_LAST  = 16'((MEAS_CYC / 8) - 1);
   localparam logic [15:0] SHORT_IV_LAST = 16'((SHORT_CYC / 8) - 1);
   localparam logic [15:0] PROC_LAST     =
      16'(((`ED_TOTAL_TIME_NS - `ED_MEAS_TIME_NS) / `CLK_PERIOD_NS) - 1);
   localparam logic [7:0]  TICK_LAST     = 8'((`STRENGTH_TIME_NS / `CLK_PERIOD_NS) - 1);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Converts a strength code to dB above the floor; code 0 stays at the floor.
   function automatic logic [9:0] strength_to_db(input logic [4:0] code);
      logic [9:0] base;
      base = {5'h00, code} - 10'h001;
      if (code == 5'h00) begin
         return 10'h000;
      end
      return 10'(base * `STRENGTH_STEP_DB);
   endfunction

   block_state_t st_r;
   block_state_t st_nxt;
   logic         in_rx;
   logic         manual_req;
   logic [9:0]   avg;
   logic [15:0]  iv_last;

   // ****************************************************************
   // Next-state logic
   // ****************************************************************

   // All register, strength and measurement behaviour is computed here.
   always_comb begin
      st_nxt     = st_r;
      st_nxt.done = 1'b0;
      in_rx      = rx.listen | rx.busy;
      manual_req = req.we && (req.addr == `OFS_ENERGY_LEVEL);
      avg        = st_r.acc >> `ED_AVG_SHIFT;
      iv_last    = st_r.short_win ? SHORT_IV_LAST : LONG_IV_LAST;

      // Strength sampling runs only in receive states and freezes otherwise.
      if (in_rx) begin
         if (st_r.tick_cnt == TICK_LAST) begin
            st_nxt.tick_cnt = 8'h00;
            if (rx.raw_strength > `STRENGTH_MAX) begin
               st_nxt.strength = `STRENGTH_MAX;
            end else begin
               st_nxt.strength = rx.raw_strength;
            end
         end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 8'h01;
         end
      end else begin
         st_nxt.tick_cnt = 8'h00;
      end

      // The checksum verdict is captured only with the frame-end strobe.
      if (rx.frame_end) begin
         st_nxt.crc_valid = rx.crc_ok;
      end

      // Control write steers the transmit checksum generator.
      if (req.we && (req.addr == `OFS_TRX_CTRL_ONE)) begin
         st_nxt.auto_crc = req.wdata[`CTRL_AUTO_CRC_BIT];
      end

      // Measurement sequencing: eight samples, then the processing delay.
      case (st_r.phase)
         ED_MEAS: begin
            if (st_r.sub_cnt == iv_last) begin
               st_nxt.sub_cnt = 16'h0000;
               st_nxt.acc     = st_r.acc + strength_to_db(st_r.strength);
               if (st_r.samp_cnt == `ED_LAST_SAMPLE) begin
                  st_nxt.phase = ED_PROC;
               end else begin
                  st_nxt.samp_cnt = st_r.samp_cnt + 3'h1;
               end
            end else begin
               st_nxt.sub_cnt = st_r.sub_cnt + 16'h0001;
            end
         end
         ED_PROC: begin
            if (st_r.sub_cnt == PROC_LAST) begin
               // The average never exceeds the top code, the clamp is a guard.
               if (avg > {2'b00, `ENERGY_MAX}) begin
                  st_nxt.energy = `ENERGY_MAX;
               end else begin
                  st_nxt.energy = avg[7:0];
               end
               st_nxt.phase = ED_IDLE;
               st_nxt.done  = st_r.manual;
            end else begin
               st_nxt.sub_cnt = st_r.sub_cnt + 16'h0001;
            end
         end
         default: begin
            st_nxt.phase = ED_IDLE;
         end
      endcase

      // A new start restarts the sequence; the old result stays readable.
      if (manual_req && !in_rx) begin
         st_nxt.done = 1'b1;
      end else if (manual_req || rx.shr_detect) begin
         st_nxt.phase     = ED_MEAS;
         st_nxt.sub_cnt   = 16'h0000;
         st_nxt.samp_cnt  = 3'h0;
         st_nxt.acc       = 10'h000;
         // A preempted manual run still owes its done event.
         st_nxt.manual    = manual_req | (st_r.manual && (st_r.phase != ED_IDLE));
         st_nxt.short_win = rx.high_rate && !(manual_req && rx.listen);
      end

      // Read answer appears one cycle after the read strobe.
      if (req.re) begin
         st_nxt.rdata = 8'h00;
         case (req.addr)
            `OFS_QUALITY_STATUS: begin
               st_nxt.rdata[`STAT_CRC_BIT] = st_r.crc_valid;
               st_nxt.rdata[`STAT_STRENGTH_MSB:`STAT_STRENGTH_LSB] = st_r.strength;
            end
            `OFS_ENERGY_LEVEL: begin
               st_nxt.rdata = st_r.energy;
            end
            `OFS_TRX_CTRL_ONE: begin
               st_nxt.rdata[`CTRL_AUTO_CRC_BIT] = st_r.auto_crc;
            end
            default: begin
               st_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   // Reset gives a never-measured energy value and auto checksum enabled.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_r           <= '0;
         st_r.phase     <= ED_IDLE;
         st_r.strength  <= `STRENGTH_RESET;
         st_r.auto_crc  <= `AUTO_CRC_RESET;
         st_r.energy    <= `ENERGY_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs are fields of the state register.
   assign rdata                  = st_r.rdata;
   assign strength               = st_r.strength;
   assign energy_value           = st_r.energy;
   assign crc_valid              = st_r.crc_valid;
   assign tx_auto_crc_en         = st_r.auto_crc;
   assign measurement_done_event = st_r.done;

   // ****************************************************************
   // Assertions
   // ****************************************************************

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   AST_AUTO_CRC_WRITE: assert property (
      req.we && (req.addr == `OFS_TRX_CTRL_ONE)
      |=> tx_auto_crc_en == $past(req.wdata[`CTRL_AUTO_CRC_BIT]))
      else $error("Auto checksum bit did not follow the control write.");

   AST_CRC_CAPTURE: assert property (
      rx.frame_end |=> crc_valid == $past(rx.crc_ok))
      else $error("Checksum valid bit does not match the frame verdict.");

   AST_CRC_HOLD: assert property (
      !rx.frame_end |=> $stable(crc_valid))
      else $error("Checksum valid bit changed without a frame end.");

   AST_STRENGTH_RANGE: assert property (
      strength <= `STRENGTH_MAX)
      else $error("Strength value above the top code.");

   AST_STRENGTH_FROZEN: assert property (
      !(rx.listen || rx.busy) |=> $stable(strength))
      else $error("Strength changed outside receive states.");

   AST_MANUAL_START: assert property (
      req.we && (req.addr == `OFS_ENERGY_LEVEL) && (rx.listen || rx.busy)
      |=> st_r.phase == ED_MEAS && st_r.manual && st_r.acc == 10'h000)
      else $error("Energy register write did not start a measurement.");

   AST_AUTO_START: assert property (
      rx.shr_detect && !(req.we && (req.addr == `OFS_ENERGY_LEVEL))
      |=> st_r.phase == ED_MEAS && st_r.samp_cnt == 3'h0)
      else $error("Preamble detection did not start a measurement.");

   AST_AUTO_NO_DONE: assert property (
      st_r.phase == ED_PROC && st_r.sub_cnt == PROC_LAST && !st_r.manual
      && !req.we |=> !measurement_done_event)
      else $error("Automatic measurement end raised a done event.");

   AST_MANUAL_DONE: assert property (
      st_r.phase == ED_PROC && st_r.sub_cnt == PROC_LAST && st_r.manual
      |=> measurement_done_event && st_r.phase != ED_PROC)
      else $error("Manual measurement end gave no done event.");

   AST_OUTSIDE_RX: assert property (
      req.we && (req.addr == `OFS_ENERGY_LEVEL) && !(rx.listen || rx.busy)
      && !rx.shr_detect && st_r.phase == ED_IDLE
      |=> measurement_done_event && st_r.phase == ED_IDLE && $stable(energy_value))
      else $error("Request outside receive states misbehaved.");

   AST_RESULT_ONLY_AT_END: assert property (
      $changed(energy_value) |-> $past(st_r.phase) == ED_PROC)
      else $error("Energy value changed outside the result step.");

   AST_SHORT_WINDOW: assert property (
      rx.shr_detect && rx.high_rate && !req.we |=> st_r.short_win)
      else $error("High-rate automatic measurement not shortened.");

   AST_ENERGY_RANGE: assert property (
      energy_value != `ENERGY_RESET |-> energy_value <= `ENERGY_MAX)
      else $error("Energy value outside the legal range.");

   // A result never falls back to the never-measured mark once stored.
   AST_NEW_RESULT_LEGAL: assert property (
      $changed(energy_value) |-> energy_value <= `ENERGY_MAX)
      else $error("Energy value changed to an illegal code.");

   // Strength refresh follows the sample at each tick, clamped to the top code.
   AST_STRENGTH_UPDATE: assert property (
      (rx.listen || rx.busy) && st_r.tick_cnt == TICK_LAST
      && rx.raw_strength <= `STRENGTH_MAX |=> strength == $past(rx.raw_strength))
      else $error("Strength not refreshed from the sample at the tick.");

   AST_STRENGTH_CLAMP: assert property (
      (rx.listen || rx.busy) && st_r.tick_cnt == TICK_LAST
      && rx.raw_strength > `STRENGTH_MAX |=> strength == `STRENGTH_MAX)
      else $error("Strength above the top code was not clamped.");

   AST_READ_STATUS: assert property (
      req.re && req.addr == `OFS_QUALITY_STATUS
      |=> rdata == {$past(crc_valid), 2'b00, $past(strength)})
      else $error("Status read does not show checksum and strength.");

   AST_READ_ENERGY: assert property (
      req.re && req.addr == `OFS_ENERGY_LEVEL |=> rdata == $past(energy_value))
      else $error("Energy read does not show the stored value.");

   AST_CTRL_HOLD: assert property (
      !(req.we && req.addr == `OFS_TRX_CTRL_ONE) |=> $stable(tx_auto_crc_en))
      else $error("Auto checksum bit changed without a control write.");

   AST_LONG_MANUAL: assert property (
      req.we && req.addr == `OFS_ENERGY_LEVEL && rx.listen |=> !st_r.short_win)
      else $error("Manual measurement in listen state was shortened.");

   AST_SAMPLES_DONE: assert property (
      st_r.phase == ED_MEAS && st_r.sub_cnt == iv_last && st_r.samp_cnt == `ED_LAST_SAMPLE
      && !req.we && !rx.shr_detect |=> st_r.phase == ED_PROC && st_r.sub_cnt == 16'h0000)
      else $error("Eighth sample did not lead to the processing step.");

   AST_START_KEEPS_RESULT: assert property (
      rx.shr_detect && st_r.phase != ED_PROC |=> $stable(energy_value))
      else $error("Starting a measurement disturbed the stored result.");

   AST_WRITE_NOT_STORED: assert property (
      req.we && req.addr == `OFS_ENERGY_LEVEL && st_r.phase != ED_PROC
      |=> $stable(energy_value))
      else $error("Energy register write stored its data.");

   AST_DONE_CAUSE: assert property (
      measurement_done_event |-> ($past(st_r.manual) && $past(st_r.phase) == ED_PROC)
      || ($past(req.we) && $past(req.addr) == `OFS_ENERGY_LEVEL
      && !$past(rx.listen) && !$past(rx.busy)))
      else $error("Done event without a manual measurement or request.");

   COV_MANUAL_DONE: cover property (
      st_r.phase == ED_PROC && st_r.manual ##1 measurement_done_event);

   COV_AUTO_RESULT: cover property (
      st_r.phase == ED_PROC && !st_r.manual ##1 st_r.phase == ED_IDLE);

   COV_OUTSIDE_RX: cover property (
      req.we && (req.addr == `OFS_ENERGY_LEVEL) && !(rx.listen || rx.busy));

   COV_CRC_GOOD: cover property (rx.frame_end && rx.crc_ok ##1 crc_valid);

   COV_SHORT_AUTO: cover property (
      rx.shr_detect && rx.high_rate ##1 st_r.short_win);

endmodule

// ### testbench/host_model.sv
// Host-side model that reaches the block's registers through its register port.
`timescale 1ns/1ps

module host_model (
   // Clock.
   input  wire logic                  clock,
   // Register port towards the block.
   output rssi_ed_pkg::reg_req_t      req,
   input  wire logic [7:0]            rdata
);
   import rssi_ed_pkg::*;

   // ****************************************************************
   // Register access
   // ****************************************************************
   // The port is quiet until the first access.
   initial begin
      req = '0;
   end

   // One-cycle write strobe; a write to the energy register only requests a run.
   task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      req.we    = 1'b1;
      req.addr  = a;
      req.wdata = d;
      @(posedge clock);
      #1;
      req.we    = 1'b0;
      req.wdata = ~d;
   endtask

   // Read strobe, then the answer is taken once it has settled and holds.
   task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
      @(posedge clock);
      #1;
      req.re   = 1'b1;
      req.addr = a;
      @(posedge clock);
      #1;
      req.re = 1'b0;
      @(posedge clock);
      #1;
      d = rdata;
   endtask
endmodule

// ### testbench/rssi_energy_detect_status_tb.sv
// Self-checking testbench for the strength, energy and checksum status block.
`timescale 1ns/1ps
`include "rssi_ed_defs.svh"

module rssi_energy_detect_status_tb;
   import rssi_ed_pkg::*;

   // ****************************************************************
   // Bench signals
   // ****************************************************************
   localparam int MEAS  = 80;
   localparam int SHORT = 16;
   logic        clock;
   logic        rst_b;
   reg_req_t    req;
   logic [7:0]  rdata;
   rx_ind_t     rx;
   logic [4:0]  strength;
   logic [7:0]  energy_value;
   logic        crc_valid;
   logic        tx_auto_crc_en;
   logic        measurement_done_event;
   logic [7:0]  rd;
   int          fails;
   int          checks;
   int          cycles;

   // Short measurement windows keep each run under 1300 cycles.
   rssi_energy_detect_status #(.MEAS_CYC(MEAS), .SHORT_CYC(SHORT)) i_dut (
      .clock(clock), .rst_b(rst_b), .req(req), .rdata(rdata), .rx(rx),
      .strength(strength), .energy_value(energy_value), .crc_valid(crc_valid),
      .tx_auto_crc_en(tx_auto_crc_en), .measurement_done_event(measurement_done_event));

   host_model i_host (.clock(clock), .req(req), .rdata(rdata));

   // Free-running 100 MHz clock.
   always #5 clock = ~clock;

   // A hang counts as a mismatch; the whole run needs well under this.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         summarize();
      end
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      chk("energy reset", 8'hff, energy_value);
      chk("auto crc reset", 8'h01, {7'h00, tx_auto_crc_en});
      i_host.read_reg(6'h07, rd);
      chk("energy read", 8'hff, rd);
      i_host.read_reg(6'h04, rd);
      chk("control read", 8'h20, rd);
   endtask

   task automatic t_ctrl();
      i_host.write_reg(6'h04, 8'hdf);
      i_host.read_reg(6'h04, rd);
      chk("control cleared", 8'h00, rd);
      chk("auto crc off", 8'h00, {7'h00, tx_auto_crc_en});
      i_host.write_reg(6'h04, 8'hff);
      i_host.read_reg(6'h04, rd);
      chk("control set", 8'h20, rd);
      chk("auto crc on", 8'h01, {7'h00, tx_auto_crc_en});
   endtask

   task automatic t_crc();
      rx.frame_end = 1'b1;
      rx.crc_ok    = 1'b1;
      cyc(1);
      rx.frame_end = 1'b0;
      rx.crc_ok    = 1'b0;
      cyc(5);
      chk("crc held good", 8'h01, {7'h00, crc_valid});
      i_host.read_reg(6'h06, rd);
      chk("status good", 8'h80, rd);
      rx.frame_end = 1'b1;
      cyc(1);
      rx.frame_end = 1'b0;
      rx.crc_ok    = 1'b1;
      cyc(3);
      chk("crc bad", 8'h00, {7'h00, crc_valid});
   endtask

   task automatic t_strength();
      rx.raw_strength = 5'h1f;
      rx.listen       = 1'b1;
      cyc(210);
      chk("strength clamp", 8'h1c, {3'h0, strength});
      rx.raw_strength = 5'h05;
      cyc(210);
      i_host.read_reg(6'h06, rd);
      chk("status strength", 8'h05, rd);
      rx.listen       = 1'b0;
      rx.raw_strength = 5'h09;
      cyc(420);
      chk("strength frozen", 8'h05, {3'h0, strength});
   endtask

   task automatic t_manual_idle();
      i_host.write_reg(6'h07, 8'h55);
      chk("idle done", 8'h01, {7'h00, measurement_done_event});
      cyc(200);
      chk("idle energy", 8'hff, energy_value);
   endtask

   task automatic t_manual_listen();
      int n;
      n = 0;
      rx.listen       = 1'b1;
      rx.raw_strength = 5'h0a;
      cyc(210);
      i_host.write_reg(6'h07, 8'h00);
      while (measurement_done_event !== 1'b1 && n < 1400) begin
         cyc(1);
         n++;
      end
      chk("manual done", 8'h01, {7'h00, measurement_done_event});
      chk("manual energy", 8'h1b, energy_value);
      chk("manual time", 8'h01, {7'h00, n >= 1270 && n <= 1290});
   endtask

   task automatic t_auto();
      int n;
      int d;
      n = 0;
      d = 0;
      rx.listen       = 1'b0;
      rx.busy         = 1'b1;
      rx.high_rate    = 1'b1;
      rx.raw_strength = 5'h1f;
      cyc(210);
      rx.shr_detect = 1'b1;
      cyc(1);
      rx.shr_detect = 1'b0;
      while (energy_value === 8'h1b && n < 1400) begin
         cyc(1);
         n++;
         if (measurement_done_event !== 1'b0) begin
            d++;
         end
      end
      chk("auto energy", 8'h51, energy_value);
      chk("auto no done", 8'h00, d[7:0]);
      chk("auto short", 8'h01, {7'h00, n >= 1210 && n <= 1230});
   endtask

   // A reset after the last run has ended must bring energy, checksum-valid, strength and auto-checksum back to their reset values.
   task automatic t_reset_mid();
      i_host.write_reg(6'h04, 8'h00);
      rx.frame_end = 1'b1;
      rx.crc_ok    = 1'b1;
      cyc(1);
      rx.frame_end = 1'b0;
      rst_b        = 1'b0;
      cyc(2);
      rst_b = 1'b1;
      cyc(2);
      chk("energy after reset", 8'hff, energy_value);
      chk("crc after reset", 8'h00, {7'h00, crc_valid});
      chk("strength after reset", 8'h00, {3'h0, strength});
      chk("auto crc after reset", 8'h01, {7'h00, tx_auto_crc_en});
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      clock  = 1'b0;
      rst_b  = 1'b0;
      rx     = '0;
      fails  = 0;
      checks = 0;
      cycles = 0;
      cyc(16);
      rst_b = 1'b1;
      t_reset();
      t_ctrl();
      t_crc();
      t_strength();
      t_manual_idle();
      t_manual_listen();
      t_auto();
      t_reset_mid();
      summarize();
   end
endmodule
